//--- bench/flash_array_model.sv
// behavioural flash array facing the sequencer
`timescale 1ns/1ps
module flash_array_model import flash_ctrl_pkg::*; (
   input wire logic clock,
   input wire array_req_s array_req,
   output logic [7:0] array_rdata
);
   initial array_rdata = 8'h00;
   // data one cycle after a read, toggling when not read
   always @(posedge clock) begin
      if (array_req.rd === 1'b1) begin
         array_rdata <= array_req.addr[7:0] + {2'b00, array_req.addr[13:8]};
      end else begin
         array_rdata <= ~array_rdata;
      end
   end
endmodule : flash_array_model

//--- bench/tb.sv
// self-checking bench for the flash program and boot control block
`timescale 1ns/1ps
module tb;
   import flash_ctrl_pkg::*;
   logic clock, reset, reg_write, reg_read, low_supply, force_loader, boot_status;
   logic code_read, code_read_ok, code_read_refused, start_valid, busy;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, boot_vector, cfg1_in, cfg2_in, cfg1_out, cfg2_out;
   logic [7:0] array_rdata, rd_val, wr_dat;
   logic [13:0] code_addr, wr_addr;
   logic [15:0] start_address;
   logic [31:0] crc_exp, crc_got;
   array_req_s array_req;
   int miscompares, cmp_count, cycles, wr_count, n;
   cmd_e ers_cmd [3] = '{cmd_erase_byte, cmd_erase_page, cmd_erase_sector};
   logic [13:0] ers_addr [3] = '{14'h0456, 14'h0440, 14'h0400};

   flash_program_boot_control #(.sectors(4), .op_count(20)) u_flash_program_boot_control (
      .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .low_supply(low_supply), .force_loader(force_loader), .boot_status(boot_status),
      .boot_vector(boot_vector), .user_config_byte_one_in(cfg1_in),
      .user_config_byte_two_in(cfg2_in), .code_read(code_read), .code_addr(code_addr),
      .code_read_ok(code_read_ok), .code_read_refused(code_read_refused),
      .start_address(start_address), .start_valid(start_valid),
      .user_config_byte_one(cfg1_out), .user_config_byte_two(cfg2_out),
      .array_req(array_req), .array_rdata(array_rdata), .busy(busy));
   flash_array_model u_flash_array_model (.clock(clock), .array_req(array_req),
      .array_rdata(array_rdata));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // cycle ceiling and array write monitor
   always @(posedge clock) begin
      cycles++;
      if (array_req.wr === 1'b1) begin
         wr_count++;
         wr_addr = array_req.addr;
         wr_dat = array_req.wdata;
      end
      if (cycles == 60000) begin
         miscompares++;
         wrap_up();
      end
   end
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd_reg
   task automatic do_reset(input logic st, input logic [7:0] vec, input logic frc);
      boot_status <= st;
      boot_vector <= vec;
      force_loader <= frc;
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      repeat (6) @(posedge clock);
      #1;
   endtask : do_reset
   task automatic wait_idle(output int k);
      k = 0;
      repeat (2) @(posedge clock);
      #1;
      while (busy !== 1'b0 && k < 20000) begin
         @(posedge clock);
         #1 k++;
      end
      // the closing array pulse is seen one edge after busy falls
      @(posedge clock);
      #1;
      chk("busy", 0, busy);
   endtask : wait_idle
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      c = c ^ {d, 24'h00_0000};
      for (int b = 0; b < 8; b++) c = c[31] ? ((c << 1) ^ crc_poly) : (c << 1);
      return c;
   endfunction : crc_byte
   task automatic wrap_up();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      {reset, reg_write, reg_read, low_supply, force_loader, boot_status, code_read} = 7'h40;
      {reg_addr, reg_wdata, boot_vector, code_addr} = 34'h0;
      cfg1_in = 8'hA5;
      cfg2_in = 8'h3C;
      do_reset(1'b1, 8'h2A, 1'b0);
      chk("start address", 16'h2A00, start_address);
      chk("start valid", 1, start_valid);
      cfg1_in <= 8'h00;
      cfg2_in <= 8'hFF;
      repeat (3) @(posedge clock);
      chk("config one", 8'hA5, cfg1_out);
      chk("config two", 8'h3C, cfg2_out);
      do_reset(1'b0, 8'h2A, 1'b0);
      chk("start address", 16'h0000, start_address);
      do_reset(1'b0, 8'h00, 1'b1);
      chk("start address", 16'h0F00, start_address);
      // erase granularities, a second command while busy on the last
      wr_reg(addr_lo_off, 8'h56);
      wr_reg(addr_hi_off, 8'h04);
      for (int i = 0; i < 3; i++) begin
         wr_count = 0;
         wr_reg(ctrl_off, {5'h00, ers_cmd[i]});
         if (i == 2) wr_reg(ctrl_off, {5'h00, cmd_erase_byte});
         wait_idle(n);
         chk("erase time", 1, n < 30);
         chk("erase writes", 1, wr_count);
         chk("erase address", ers_addr[i], wr_addr);
         rd_reg(ctrl_off, rd_val);
         chk("ctrl flags", {1'b1, i == 2, 2'b00}, rd_val[7:4]);
      end
      low_supply <= 1'b1;
      repeat (5) @(posedge clock);
      wr_count = 0;
      wr_reg(ctrl_off, {5'h00, cmd_erase_page});
      repeat (3) @(posedge clock);
      rd_reg(ctrl_off, rd_val);
      chk("blocked flag", 1, rd_val[5]);
      chk("blocked writes", 0, wr_count);
      low_supply <= 1'b0;
      repeat (5) @(posedge clock);
      // partial page program of two bytes
      wr_reg(addr_lo_off, 8'h40);
      wr_reg(data_off, 8'h11);
      wr_reg(addr_lo_off, 8'h7F);
      wr_reg(data_off, 8'h22);
      wr_count = 0;
      wr_reg(ctrl_off, {5'h00, cmd_program});
      wait_idle(n);
      chk("program writes", 2, wr_count);
      chk("program address", 14'h047F, wr_addr);
      chk("program data", 8'h22, wr_dat);
      // secured sector one, open sector zero
      wr_reg(secure_off, 8'h01);
      rd_reg(secure_off, rd_val);
      chk("security", 8'h02, rd_val);
      @(posedge clock);
      code_read <= 1'b1;
      code_addr <= 14'h0456;
      @(negedge clock);
      chk("secured read", 2'b10, {code_read_refused, code_read_ok});
      @(posedge clock);
      code_addr <= 14'h0056;
      @(negedge clock);
      chk("open read", 2'b01, {code_read_refused, code_read_ok});
      code_read <= 1'b0;
      // crc over sector one, then over the whole space
      for (int j = 0; j < 2; j++) begin
         crc_exp = crc_seed;
         for (int a = (j == 0 ? 1024 : 0); a < (j == 0 ? 2048 : 4096); a++) begin
            crc_exp = crc_byte(crc_exp, 8'(a) + 8'(a >> 8));
         end
         wr_reg(ctrl_off, {5'h00, (j == 0) ? cmd_crc_sector : cmd_crc_all});
         wait_idle(n);
         for (int k = 0; k < 4; k++) begin
            rd_reg(crc0_off + 4'(k), rd_val);
            crc_got[8*k +: 8] = rd_val;
         end
         chk("crc", crc_exp, crc_got);
      end
      wrap_up();
   end
endmodule : tb

//--- verilog/crc32_step.sv
// one byte step of a 32-bit crc
`timescale 1ns/1ps
module crc32_step import flash_ctrl_pkg::*; (
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data,
   output logic [31:0] crc_out
);
   logic [31:0] stage [0:8];
   assign stage[0] = crc_in ^ {data, 24'h00_0000};
   genvar i;
   // shift per bit
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         assign stage[i+1] = stage[i][31] ? ({stage[i][30:0], 1'b0} ^ crc_poly)
                                          : {stage[i][30:0], 1'b0};
      end
   endgenerate
   assign crc_out = stage[8];
endmodule : crc32_step

//--- verilog/flash_ctrl_pkg.sv
// constants, types and register map for the flash program and boot control block
package flash_ctrl_pkg;
   // ---------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------
   localparam int sector_bytes = 1024;
   localparam int page_bytes = 64;
   localparam int addr_w = 14;
   localparam int max_sectors = 16;
   localparam int loader_bytes = 512;
   // ---------------------------------------------------------------
   // register offsets on the plain port
   // ---------------------------------------------------------------
   localparam logic [3:0] ctrl_off = 4'h0;
   localparam logic [3:0] data_off = 4'h1;
   localparam logic [3:0] addr_lo_off = 4'h2;
   localparam logic [3:0] addr_hi_off = 4'h3;
   localparam logic [3:0] crc0_off = 4'h4;
   localparam logic [3:0] crc1_off = 4'h5;
   localparam logic [3:0] crc2_off = 4'h6;
   localparam logic [3:0] crc3_off = 4'h7;
   localparam logic [3:0] secure_off = 4'h8;
   localparam logic [3:0] boot_off = 4'h9;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int cmd_lsb = 0;
   localparam int busy_bit = 4;
   localparam int blocked_bit = 5;
   localparam int refused_bit = 6;
   localparam int done_bit = 7;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int clock_hz = 40_000_000;
   localparam int op_time_us = 2000;
   localparam int op_cycles = op_time_us * (clock_hz / 1_000_000);
   // ---------------------------------------------------------------
   // boot
   // ---------------------------------------------------------------
   localparam logic [15:0] reset_start = 16'h0000;
   localparam logic [7:0] boot_low = 8'h00;
   localparam logic [7:0] vec_4k = 8'h0F;
   localparam logic [7:0] vec_8k = 8'h1F;
   localparam logic [7:0] vec_16k = 8'h3F;
   localparam logic [31:0] crc_poly = 32'h04C1_1DB7;
   localparam logic [31:0] crc_seed = 32'hFFFF_FFFF;

   typedef enum logic [2:0] {
      cmd_none, cmd_load, cmd_program, cmd_erase_byte,
      cmd_erase_page, cmd_erase_sector, cmd_crc_sector, cmd_crc_all
   } cmd_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [addr_w-1:0] addr;
      logic [7:0] wdata;
   } array_req_s;
endpackage : flash_ctrl_pkg

//--- verilog/flash_program_boot_control.sv
// flash program, erase, protection, crc and boot address control
// Contract
// - code flash in 1 kB sectors of 64-byte pages, four/eight/sixteen sectors
// - page buffer programs one to 64 bytes in one operation
// - erase by sector, page or single byte
// - code-space data reads refused in secured sectors
// - 32-bit crc over one sector or all user code
// - low supply below 2.4 V blocks erase and program
// - each program or erase finishes within 2 ms, internally timed; a program adds its 64 page-write cycles before the 2 ms wait
// - programming through control/status, data and two address registers
// - boot status zero starts execution at 0000H
// - nonzero boot status starts at boot vector high, 00H low
// - default boot vector 0FH, 1FH or 3FH by size
// - forced loader entry at power-on acts like nonzero boot status
// - shipped loader sits in upper 512 bytes, erasable
// - two config bytes captured at power-up, fixed afterwards
// - one security byte per sector guards only that sector; the code keeps one set-only protect bit per sector
// - serial port programming by hardware plus loader firmware
`timescale 1ns/1ps
module flash_program_boot_control import flash_ctrl_pkg::*; #(
   parameter int sectors = max_sectors,
   parameter int op_count = op_cycles
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   input wire logic low_supply,
   input wire logic force_loader,
   input wire logic boot_status,
   input wire logic [7:0] boot_vector,
   input wire logic [7:0] user_config_byte_one_in,
   input wire logic [7:0] user_config_byte_two_in,
   input wire logic code_read,
   input wire logic [addr_w-1:0] code_addr,
   output logic code_read_ok,
   output logic code_read_refused,
   output logic [15:0] start_address,
   output logic start_valid,
   output logic [7:0] user_config_byte_one,
   output logic [7:0] user_config_byte_two,
   output array_req_s array_req,
   input wire logic [7:0] array_rdata,
   output logic busy
);
   // ---------------------------------------------------------------
   // geometry checks and derived constants
   // ---------------------------------------------------------------
   initial if (sectors != 4 && sectors != 8 && sectors != 16)
      $error("flash_program_boot_control: sectors must be 4, 8 or 16");
   localparam int top_addr = sectors * sector_bytes - 1;
   localparam logic [7:0] default_vector = (sectors == 4) ? vec_4k :
                                           (sectors == 8) ? vec_8k : vec_16k;
   localparam int loader_base = sectors * sector_bytes - loader_bytes;
   // default entry must land inside the shipped loader
   initial if ({default_vector, boot_low} < 16'(loader_base))
      $error("flash_program_boot_control: default vector outside loader area");

   // ---------------------------------------------------------------
   // pin synchronisers (three stages, second and third must agree)
   // ---------------------------------------------------------------
   logic [2:0] supply_sync_reg;
   logic [2:0] force_sync_reg;
   logic supply_low_reg;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         supply_sync_reg <= 3'h0;
         force_sync_reg <= 3'h0;
      end else begin
         supply_sync_reg <= {supply_sync_reg[1:0], low_supply};
         force_sync_reg <= {force_sync_reg[1:0], force_loader};
      end
   end
   // filtered supply level
   always_ff @(posedge clock or posedge reset) begin
      if (reset) supply_low_reg <= 1'b1;
      else if (supply_sync_reg[1] == supply_sync_reg[2]) supply_low_reg <= supply_sync_reg[2];
   end
   wire force_agree = force_sync_reg[1] & force_sync_reg[2];

   // ---------------------------------------------------------------
   // power-up capture: boot address and config bytes
   // ---------------------------------------------------------------
   logic [2:0] capture_cnt_reg;
   logic [15:0] start_reg;
   logic [7:0] cfg1_reg;
   logic [7:0] cfg2_reg;
   // capture waits until the third stage of the forced pin has settled
   wire capture_now = (capture_cnt_reg == 3'h3);
   wire [7:0] vector_used = (boot_vector == 8'h00) ? default_vector : boot_vector;
   // zero status starts at reset vector
   // nonzero status uses vector high byte
   // forced loader behaves as nonzero status
   // blank vector falls back to top sector default
   // forced entry hands the core to the serial loader
   wire [15:0] start_next = (boot_status | force_agree) ? {vector_used, boot_low} : reset_start;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) capture_cnt_reg <= 3'h0;
      else if (capture_cnt_reg != 3'h4) capture_cnt_reg <= capture_cnt_reg + 3'h1;
   end
   // config captured once after reset, read-only later
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         start_reg <= reset_start;
         cfg1_reg <= 8'h00;
         cfg2_reg <= 8'h00;
      end else if (capture_now) begin
         start_reg <= start_next;
         cfg1_reg <= user_config_byte_one_in;
         cfg2_reg <= user_config_byte_two_in;
      end
   end
   assign start_address = start_reg;
   assign start_valid = (capture_cnt_reg == 3'h4);
   assign user_config_byte_one = cfg1_reg;
   assign user_config_byte_two = cfg2_reg;

   // ---------------------------------------------------------------
   // registers and page buffer
   // ---------------------------------------------------------------
   typedef enum {st_idle, st_pulse, st_program, st_crc} state_e;
   state_e state_reg;
   logic [7:0] data_reg;
   logic [addr_w-1:0] addr_reg;
   logic [2:0] cmd_reg;
   logic [max_sectors-1:0] secure_reg;
   logic blocked_reg, refused_reg, done_reg;
   logic [7:0] page_buf [0:page_bytes-1];
   logic [page_bytes-1:0] buf_valid_reg;
   logic [5:0] prog_idx_reg;
   logic [31:0] crc_reg;
   logic [addr_w-1:0] crc_end_reg;
   logic [7:0] rdata_reg;
   logic [addr_w-1:0] array_addr_reg;
   logic array_wr_reg, array_rd_reg, crc_rd_pend_reg;
   logic [7:0] array_wdata_reg;
   logic timer_start;
   logic timer_expired;

   wire wr_ctrl = reg_write && reg_addr == ctrl_off;
   wire wr_data = reg_write && reg_addr == data_off;
   wire wr_alo = reg_write && reg_addr == addr_lo_off;
   wire wr_ahi = reg_write && reg_addr == addr_hi_off;
   wire wr_sec = reg_write && reg_addr == secure_off;
   wire [2:0] cmd_req = reg_wdata[cmd_lsb +: 3];
   wire idle = (state_reg == st_idle);
   wire is_write_cmd = cmd_req inside {cmd_program, cmd_erase_byte, cmd_erase_page,
                                       cmd_erase_sector};
   // low supply refuses every write or erase
   wire block_req = wr_ctrl && idle && is_write_cmd && supply_low_reg;
   wire drop_req = wr_ctrl && !idle && cmd_req != cmd_none;
   wire start_req = wr_ctrl && idle && cmd_req != cmd_none && !block_req;
   wire [5:0] page_off = addr_reg[5:0];
   wire [3:0] addr_sector = addr_reg[13:10];

   op_timer #(.cycles(op_count)) u_timer (
      .clock(clock),
      .reset(reset),
      .start(timer_start),
      .expired(timer_expired)
   );
   wire [31:0] crc_step_out;
   crc32_step u_crc (
      .crc_in(crc_reg),
      .data(array_rdata),
      .crc_out(crc_step_out)
   );

   // page buffer holds one to 64 bytes per page
   always_ff @(posedge clock) begin
      if (wr_data && idle) page_buf[page_off] <= reg_wdata;
   end

   // address, data, security bits
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         data_reg <= 8'h00;
         addr_reg <= '0;
         secure_reg <= '0;
      end else begin
         if (wr_data && idle) data_reg <= reg_wdata;
         if (wr_alo && idle) addr_reg[7:0] <= reg_wdata;
         if (wr_ahi && idle) addr_reg[addr_w-1:8] <= reg_wdata[addr_w-9:0];
         // one protect bit per sector, set-only until reset
         if (wr_sec) secure_reg[reg_wdata[3:0]] <= 1'b1;
      end
   end

   // status flags; hardware set wins over software clear
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         blocked_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         if (block_req) blocked_reg <= 1'b1;
         else if (wr_ctrl && !reg_wdata[blocked_bit]) blocked_reg <= 1'b0;
         if (drop_req) refused_reg <= 1'b1;
         else if (wr_ctrl && !reg_wdata[refused_bit]) refused_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // operation sequencer
   // ---------------------------------------------------------------
   wire [addr_w-1:0] page_base = {addr_reg[addr_w-1:6], 6'h00};
   // sector field above the page field
   wire [addr_w-1:0] sect_base = {addr_sector, 10'h000};
   wire [addr_w-1:0] pulse_addr = (cmd_reg == cmd_erase_page) ? page_base :
                                  (cmd_reg == cmd_erase_sector) ? sect_base : addr_reg;
   // one load on entry to the pulse state, never while it runs
   assign timer_start = (start_req && cmd_req inside {cmd_erase_byte, cmd_erase_page,
                         cmd_erase_sector}) || (state_reg == st_program && prog_idx_reg == 6'h3F);
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= st_idle;
         cmd_reg <= cmd_none;
         done_reg <= 1'b0;
         buf_valid_reg <= '0;
         prog_idx_reg <= 6'h00;
         crc_reg <= crc_seed;
         crc_end_reg <= '0;
         array_addr_reg <= '0;
         array_wr_reg <= 1'b0;
         array_rd_reg <= 1'b0;
         crc_rd_pend_reg <= 1'b0;
         array_wdata_reg <= 8'h00;
      end else begin
         array_wr_reg <= 1'b0;
         array_rd_reg <= 1'b0;
         crc_rd_pend_reg <= array_rd_reg;
         if (wr_data && idle) buf_valid_reg[page_off] <= 1'b1;
         case (state_reg)
            st_idle: if (start_req) begin
               cmd_reg <= cmd_req;
               done_reg <= 1'b0;
               case (cmd_req)
                  cmd_erase_byte, cmd_erase_page, cmd_erase_sector: state_reg <= st_pulse;
                  cmd_program: begin
                     prog_idx_reg <= 6'h00;
                     state_reg <= st_program;
                  end
                  // crc over one sector or whole space
                  cmd_crc_sector: begin
                     crc_reg <= crc_seed;
                     array_addr_reg <= sect_base;
                     crc_end_reg <= sect_base + addr_w'(sector_bytes - 1);
                     state_reg <= st_crc;
                  end
                  cmd_crc_all: begin
                     crc_reg <= crc_seed;
                     array_addr_reg <= '0;
                     crc_end_reg <= addr_w'(top_addr);
                     state_reg <= st_crc;
                  end
                  default: done_reg <= 1'b1;
               endcase
            end
            // each pulse spaced by the internal timer
            st_pulse: if (timer_expired) begin
               // the closing wait of a page program writes nothing
               array_wr_reg <= (cmd_reg != cmd_program);
               array_addr_reg <= pulse_addr;
               array_wdata_reg <= data_reg;
               state_reg <= st_idle;
               done_reg <= 1'b1;
               buf_valid_reg <= '0;
            end
            // every loaded byte of the page written in one operation
            st_program: begin
               if (buf_valid_reg[prog_idx_reg]) begin
                  array_wr_reg <= 1'b1;
                  array_addr_reg <= {addr_reg[addr_w-1:6], prog_idx_reg};
                  array_wdata_reg <= page_buf[prog_idx_reg];
               end
               prog_idx_reg <= prog_idx_reg + 6'h01;
               if (prog_idx_reg == 6'h3F) state_reg <= st_pulse;
            end
            st_crc: begin
               if (!array_rd_reg && !crc_rd_pend_reg) array_rd_reg <= 1'b1;
               if (crc_rd_pend_reg) begin
                  crc_reg <= crc_step_out;
                  if (array_addr_reg == crc_end_reg) begin
                     state_reg <= st_idle;
                     done_reg <= 1'b1;
                  end else array_addr_reg <= array_addr_reg + addr_w'(1);
               end
            end
            default: state_reg <= st_idle;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // array port, secured reads, busy
   // ---------------------------------------------------------------
   // array request straight from the sequencer flops
   assign array_req = '{wr: array_wr_reg, rd: array_rd_reg, addr: array_addr_reg,
                        wdata: array_wdata_reg};
   assign busy = !idle;
   wire code_sec = secure_reg[code_addr[13:10]];
   assign code_read_ok = code_read && !code_sec && code_addr <= addr_w'(top_addr);
   assign code_read_refused = code_read && !code_read_ok;

   wire [7:0] ctrl_view = {done_reg, refused_reg, blocked_reg, busy, 1'b0, cmd_reg};
   wire [7:0] rdata_next = (reg_addr == ctrl_off) ? ctrl_view :
                           (reg_addr == data_off) ? data_reg :
                           (reg_addr == addr_lo_off) ? addr_reg[7:0] :
                           (reg_addr == addr_hi_off) ? {2'b00, addr_reg[addr_w-1:8]} :
                           (reg_addr == crc0_off) ? crc_reg[7:0] :
                           (reg_addr == crc1_off) ? crc_reg[15:8] :
                           (reg_addr == crc2_off) ? crc_reg[23:16] :
                           (reg_addr == crc3_off) ? crc_reg[31:24] :
                           (reg_addr == secure_off) ? secure_reg[7:0] :
                           (reg_addr == boot_off) ? start_reg[15:8] : 8'h00;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) rdata_reg <= 8'h00;
      else if (reg_read) rdata_reg <= rdata_next;
      else rdata_reg <= 8'h00;
   end
   assign reg_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   secure_refuse_a: assert property (@(posedge clock) disable iff (reset)
      code_read && secure_reg[code_addr[13:10]] |-> code_read_refused)
      else $error("secured read not refused");
   low_supply_a: assert property (@(posedge clock) disable iff (reset)
      supply_low_reg && idle |-> ##1 !array_req.wr)
      else $error("write while supply low");
   busy_drop_a: assert property (@(posedge clock) disable iff (reset)
      !idle && wr_ctrl |=> $stable(cmd_reg) || state_reg != st_pulse)
      else $error("request taken while busy");
   boot_zero_a: assert property (@(posedge clock) disable iff (reset)
      start_valid && $past(capture_now) && !$past(boot_status) && !$past(force_agree)
      |-> start_address == reset_start)
      else $error("boot status zero not at reset vector");
   boot_vec_a: assert property (@(posedge clock) disable iff (reset)
      capture_now && boot_status && boot_vector != 8'h00 |=> start_address == {$past(boot_vector), boot_low})
      else $error("boot vector address wrong");
   config_fixed_a: assert property (@(posedge clock) disable iff (reset)
      start_valid && $past(start_valid) |-> $stable(user_config_byte_one))
      else $error("config byte changed after power-up");
   blocked_flag_a: assert property (@(posedge clock) disable iff (reset)
      block_req |=> blocked_reg && idle)
      else $error("blocked request not flagged");
   crc_start_a: assert property (@(posedge clock) disable iff (reset)
      start_req && cmd_req == cmd_crc_all |=> state_reg == st_crc && crc_reg == crc_seed)
      else $error("crc not started");
endmodule : flash_program_boot_control

//--- verilog/op_timer.sv
// timer that spaces one program or erase pulse
`timescale 1ns/1ps
module op_timer import flash_ctrl_pkg::*; #(
   parameter int cycles = op_cycles
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   output logic expired
);
   initial if (cycles < 1) $error("op_timer: cycles must be positive");
   logic [31:0] count_reg;
   // countdown, expired pulses on final cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) count_reg <= 32'h0000_0000;
      else if (start) count_reg <= 32'(cycles);
      else if (count_reg != 32'h0000_0000) count_reg <= count_reg - 32'h0000_0001;
   end
   assign expired = (count_reg == 32'h0000_0001);
endmodule : op_timer
